// ---- lpi_intensity.sv ----
// led intensity registers and the pwm engine they steer
// assumes the serial front end presents single-cycle register strobes on clk
`include "lpi_defs.svh"

// Summary of operation
// - intensity register holds master level high nibble, ninth level low nibble.
// - reading intensity register returns master and ninth levels as last written.
// - master code zero: off, oscillator stopped, all outputs static.
// - master codes 1 to 15 give master duty of code over fifteen.
// - ninth-output codes 0 to 14 give duty of code plus one sixteenths.
// - ninth-output all-ones code is full duty, static, no modulation.
// - port register holds port one high nibble, port zero low nibble.
// - reading port register returns both stored port levels unchanged.
// - port one code n gives (n+1)/16 duty; all-ones is static.
// - port zero uses the same encoding as port one.
// - blink phase one inverts the low window; code f gives static levels.
module lpi_intensity
  import lpi_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // register port from the serial front end
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  output logic      [7:0]   reg_rdata_r,
  // blink control from the blink-phase registers
  input  wire logic         blink_enable,
  input  wire logic         port_zero_phase,
  input  wire logic         port_one_phase,
  input  wire logic         ninth_phase,
  // open-drain outputs, enable low while pulling the pin low
  output logic              port_zero_output_oe_n_r,
  output logic              port_one_output_oe_n_r,
  output logic              ninth_output_oe_n_r
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  lpi_level_type master_level_r;
  lpi_level_type ninth_level_r;
  lpi_level_type port_one_level_r;
  lpi_level_type port_zero_level_r;
  lpi_byte_type  reg_rdata_nxt;

  // address decode
  wire logic hit_master = (reg_addr == `LPI_ADDR_MASTER);
  wire logic hit_port10 = (reg_addr == `LPI_ADDR_PORT10);
  wire logic wr_master  = reg_wr & hit_master;
  wire logic wr_port10  = reg_wr & hit_port10;

  // readback mux; unmapped addresses read zero
  assign reg_rdata_nxt = !reg_rd    ? reg_rdata_r :
                         hit_master ? {master_level_r, ninth_level_r} :
                         hit_port10 ? {port_one_level_r, port_zero_level_r} :
                                      `LPI_RESET_DATA;

  // master and ninth nibbles written together
  always_ff @(posedge clk) begin
    if (rst) begin
      master_level_r <= `LPI_RESET_LEVEL;
      ninth_level_r  <= `LPI_RESET_LEVEL;
    end else if (wr_master) begin
      master_level_r <= reg_wdata[`LPI_HI_MSB:`LPI_HI_LSB];
      ninth_level_r  <= reg_wdata[`LPI_LO_MSB:`LPI_LO_LSB];
    end
  end

  // port one and port zero nibbles written together
  always_ff @(posedge clk) begin
    if (rst) begin
      port_one_level_r  <= `LPI_RESET_LEVEL;
      port_zero_level_r <= `LPI_RESET_LEVEL;
    end else if (wr_port10) begin
      port_one_level_r  <= reg_wdata[`LPI_HI_MSB:`LPI_HI_LSB];
      port_zero_level_r <= reg_wdata[`LPI_LO_MSB:`LPI_LO_LSB];
    end
  end

  // read data registered, answers one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) reg_rdata_r <= `LPI_RESET_DATA;
    else     reg_rdata_r <= reg_rdata_nxt;
  end

  // ----------------------------------------------------------------
  // shared period counter
  // ----------------------------------------------------------------
  // slot counts 0..14 inside each sub-step, step counts 0..15 per period
  lpi_level_type slot_r;
  lpi_level_type step_r;
  lpi_level_type slot_nxt;
  lpi_level_type step_nxt;

  wire logic osc_run   = (master_level_r != `LPI_MASTER_OFF);
  wire logic slot_wrap = (slot_r == `LPI_SLOT_LAST);

  // oscillator stopped and counter parked while master is off
  // single counter feeds every output so they stay in phase
  assign slot_nxt = !osc_run  ? `LPI_CNT_ZERO :
                    slot_wrap ? `LPI_CNT_ZERO : slot_r + `LPI_CNT_ONE;
  assign step_nxt = !osc_run  ? `LPI_CNT_ZERO :
                    slot_wrap ? step_r + `LPI_CNT_ONE : step_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      slot_r <= `LPI_CNT_ZERO;
      step_r <= `LPI_CNT_ZERO;
    end else begin
      slot_r <= slot_nxt;
      step_r <= step_nxt;
    end
  end

  // master window: code out of fifteen slots is active
  wire logic master_win = (slot_r < master_level_r);

  // ----------------------------------------------------------------
  // per-output waveform
  // ----------------------------------------------------------------
  // index 0 port zero, 1 port one, 2 ninth output
  lpi_level_type level   [3];
  logic [2:0]    phase;
  logic [2:0]    sink_nxt;
  logic [2:0]    oe_n_r;

  assign level[0] = port_zero_level_r;
  assign level[1] = port_one_level_r;
  assign level[2] = ninth_level_r;
  assign phase    = {ninth_phase, port_one_phase, port_zero_phase};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_out
      wire logic is_static = (level[g] == `LPI_CODE_STATIC);
      wire logic step_win  = (step_r <= level[g]);
      // step window gated by the master window
      wire logic pwm_low   = is_static | (step_win & master_win);
      // phase one inverts the low time while blinking
      wire logic invert    = blink_enable & phase[g];
      // master off leaves the pin released, static
      assign sink_nxt[g]   = osc_run & (pwm_low ^ invert);

      always_ff @(posedge clk) begin
        if (rst) oe_n_r[g] <= `LPI_PIN_RELEASED;
        else     oe_n_r[g] <= ~sink_nxt[g];
      end
    end
  endgenerate

  // registered pins, already flip-flop outputs
  assign port_zero_output_oe_n_r = oe_n_r[0];
  assign port_one_output_oe_n_r  = oe_n_r[1];
  assign ninth_output_oe_n_r     = oe_n_r[2];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire logic inv0 = blink_enable & port_zero_phase;
  wire logic inv1 = blink_enable & port_one_phase;
  wire logic inv2 = blink_enable & ninth_phase;

  a_master_write_fields: assert property (@(posedge clk) disable iff (rst)
    wr_master |=> master_level_r == $past(reg_wdata[`LPI_HI_MSB:`LPI_HI_LSB])
                  && ninth_level_r == $past(reg_wdata[`LPI_LO_MSB:`LPI_LO_LSB]))
    else $error("intensity register write not stored");

  a_unmapped_read_zero: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && !hit_master && !hit_port10) |=> reg_rdata_r == `LPI_RESET_DATA)
    else $error("unmapped register read not zero");

  a_master_read_back: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && hit_master) |=> reg_rdata_r == {$past(master_level_r), $past(ninth_level_r)})
    else $error("intensity register readback wrong");

  a_port_write_read: assert property (@(posedge clk) disable iff (rst)
    (wr_port10 ##1 (reg_rd && hit_port10 && !reg_wr)) |=> reg_rdata_r == $past(reg_wdata, 2))
    else $error("port register readback wrong");

  a_osc_stopped: assert property (@(posedge clk) disable iff (rst)
    (master_level_r == `LPI_MASTER_OFF) |=> (slot_r == `LPI_CNT_ZERO && step_r == `LPI_CNT_ZERO
                                             && port_zero_output_oe_n_r
                                             && port_one_output_oe_n_r && ninth_output_oe_n_r))
    else $error("outputs or counter active with master off");

  a_slot_wrap_count: assert property (@(posedge clk) disable iff (rst)
    (osc_run && slot_r == `LPI_SLOT_LAST && $stable(master_level_r))
      |=> slot_r == `LPI_CNT_ZERO && step_r == $past(step_r) + `LPI_CNT_ONE)
    else $error("shared counter did not wrap correctly");

  a_port_zero_window: assert property (@(posedge clk) disable iff (rst)
    (osc_run && !inv0 && port_zero_level_r != `LPI_CODE_STATIC && step_r <= port_zero_level_r && master_win)
      |=> !port_zero_output_oe_n_r)
    else $error("port zero not sinking inside its window");

  a_blink_inverts_window: assert property (@(posedge clk) disable iff (rst)
    (osc_run && inv0 && port_zero_level_r != `LPI_CODE_STATIC && step_r <= port_zero_level_r && master_win)
      |=> port_zero_output_oe_n_r)
    else $error("port zero not released inside its window while inverted");

  a_master_gate_off: assert property (@(posedge clk) disable iff (rst)
    (osc_run && !inv0 && port_zero_level_r != `LPI_CODE_STATIC && !master_win) |=> port_zero_output_oe_n_r)
    else $error("port zero sinking outside master window");

  a_port_one_static: assert property (@(posedge clk) disable iff (rst)
    (osc_run && !inv1 && port_one_level_r == `LPI_CODE_STATIC) |=> !port_one_output_oe_n_r)
    else $error("port one not static at full code");

  a_port_one_past_window: assert property (@(posedge clk) disable iff (rst)
    (osc_run && !inv1 && port_one_level_r != `LPI_CODE_STATIC && step_r > port_one_level_r) |=> port_one_output_oe_n_r)
    else $error("port one sinking after its window");

  a_ninth_static_low: assert property (@(posedge clk) disable iff (rst)
    (osc_run && !inv2 && ninth_level_r == `LPI_CODE_STATIC) [*2] |=> !ninth_output_oe_n_r [*1])
    else $error("ninth output not static at full code");

  a_ninth_past_window: assert property (@(posedge clk) disable iff (rst)
    (osc_run && !inv2 && ninth_level_r != `LPI_CODE_STATIC && step_r > ninth_level_r) |=> ninth_output_oe_n_r)
    else $error("ninth output sinking after its window");

endmodule : lpi_intensity

// ---- lpi_defs.svh ----
// constants for the led intensity register block
// assumes it is included by bare name from the package and the design
`ifndef LPI_DEFS_SVH
`define LPI_DEFS_SVH

// register addresses as seen on the internal register port
`define LPI_ADDR_MASTER   8'h0e
`define LPI_ADDR_PORT10   8'h10

// field positions (high nibble, low nibble)
`define LPI_HI_MSB        7
`define LPI_HI_LSB        4
`define LPI_LO_MSB        3
`define LPI_LO_LSB        0

// power-up value, leaves pwm disabled
`define LPI_RESET_LEVEL   4'h0
`define LPI_RESET_DATA    8'h00

// open-drain enable level while the pin is let go
`define LPI_PIN_RELEASED  1'b1

// special codes
`define LPI_MASTER_OFF    4'h0
`define LPI_CODE_STATIC   4'hf

// period structure: 16 sub-steps, each split into 15 master slots
`define LPI_SLOT_LAST     4'he
`define LPI_STEP_LAST     4'hf
`define LPI_CNT_ZERO      4'h0
`define LPI_CNT_ONE       4'h1

`endif

// ---- lpi_pkg.sv ----
// types shared by the led intensity register block
// assumes lpi_defs.svh is on the include path
`include "lpi_defs.svh"

package lpi_pkg;
  // one 4-bit intensity code
  typedef logic [3:0] lpi_level_type;
  // one register byte
  typedef logic [7:0] lpi_byte_type;
endpackage : lpi_pkg

// ---- lpi_host_model.sv ----
// host side of the register port, standing in for the serial front end
// assumes one caller at a time; one strobe cycle per access
module lpi_host_model (
  // clock
  input  wire logic       clk,
  // register port toward the device
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port at time zero, no strobe
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one access: strobe held over one rising edge, then address and data
  // turn to their inverse so stale values never look valid
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_wr = wr;
    reg_rd = ~wr;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask : xfer

  // write then read of one address on two consecutive edges
  task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_rd = 1'b0;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask : wr_rd
endmodule : lpi_host_model

// ---- lpi_intensity_test.sv ----
// self-checking bench for the led intensity registers and pwm engine
// assumes lpi_host_model drives the register port
module lpi_intensity_test
  import lpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, reg_wr, reg_rd, blink, ph0, ph1, ph8, rd_q, pend;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, n0, n1, n8;
  logic p0_n, p1_n, p8_n;
  logic [31:0] seed = 32'h00015eaa;
  lpi_byte_type exp_q[$];
  int num_errors = 0;
  int compares = 0;
  lpi_level_type m, c8, c1, c0;

  // clock and reset inputs
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  lpi_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  lpi_intensity dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .blink_enable(blink), .port_zero_phase(ph0),
    .port_one_phase(ph1), .ninth_phase(ph8), .port_zero_output_oe_n_r(p0_n),
    .port_one_output_oe_n_r(p1_n), .ninth_output_oe_n_r(p8_n));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  // low clocks per 240-clock period; master off always releases
  function automatic logic [7:0] expc(lpi_level_type mm, lpi_level_type cc, logic inv);
    logic [7:0] b;
    b = (cc == 4'hf) ? 8'hf0 : ({4'h0, cc} + 8'h01) * {4'h0, mm};
    if (mm == 4'h0) return 8'h00;
    return inv ? 8'hf0 - b : b;
  endfunction : expc

  task automatic rd(input logic [7:0] addr, input lpi_byte_type want);
    exp_q.push_back(want);
    host.xfer(1'b0, addr, 8'h00);
  endtask : rd

  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // read data lands one edge after the strobe, so compare a cycle and a half later
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk) begin
    if (pend) check("read data", reg_rdata_r, exp_q.pop_front());
    pend = rd_q;
  end

  // watchdog: eight cases of two periods each plus register traffic, about 4000 clocks
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    {rst, blink, ph0, ph1, ph8, pend} = 6'h20;
    // two rising edges in reset, released off the sampling edge
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // cleared registers and the unmapped hole read as zero
    rd(8'h0e, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h0f, 8'h00);
    $display("reset reads done");
    for (int i = 0; i < 8; i++) begin
      {m, c8, c1, c0} = 16'(xs());
      if (i == 0) m = 4'h0;
      if (i == 1) {m, c8, c1, c0} = 16'hfff0;
      @(negedge clk);
      {blink, ph0, ph1, ph8} = (i < 2) ? 4'h0 : (i == 2) ? 4'hf : 4'(xs());
      // nibble placement on write, port register read straight after its write
      host.xfer(1'b1, 8'h0e, {m, c8});
      exp_q.push_back({c1, c0});
      host.wr_rd(8'h10, {c1, c0});
      rd(8'h0e, {m, c8});
      repeat (240) begin
        @(negedge clk);
        {n0, n1, n8} = {n0 + {7'h00, ~p0_n}, n1 + {7'h00, ~p1_n}, n8 + {7'h00, ~p8_n}};
      end
      {n0, n1, n8} = 24'h000000;
      repeat (240) begin
        @(negedge clk);
        {n0, n1, n8} = {n0 + {7'h00, ~p0_n}, n1 + {7'h00, ~p1_n}, n8 + {7'h00, ~p8_n}};
      end
      check("port zero lows", n0, expc(m, c0, blink & ph0));
      check("port one lows", n1, expc(m, c1, blink & ph1));
      check("ninth lows", n8, expc(m, c8, blink & ph8));
      $display("duty case %0d done", i);
    end
    end_of_test();
  end
endmodule : lpi_intensity_test
